/* bpw_pkg.sv */
// Constants shared by the prefetch and I/O window register block
//
// Overview of operation
// - Limit bits 15:4 give address bits 31:20
// - Limit top address low 20 bits read ones
// - Limit bits 3:0 read-only, register resets 0001h
// - Offset 28h holds base upper 32, reset zero
// - Offset 2Ch holds limit upper 32, reset zero
// - Limit upper word forms address bits 63:32
// - Prefetch window decides memory forwarding
// - Offset 30h holds I/O base upper 16
// - I/O base low bits taken as zeros
// - I/O window decides I/O forwarding downstream
// - Base bits 15:4 give address bits 31:20
//
`default_nettype none
package bpw_pkg;

   // ************************************************************
   // Configuration offsets (bytes)
   // ************************************************************
   localparam logic [7:0] OFF_PREF_BASE      = 8'h24;
   localparam logic [7:0] OFF_PREF_LIMIT     = 8'h26;
   localparam logic [7:0] OFF_PREF_BASE_HIGH = 8'h28;
   localparam logic [7:0] OFF_PREF_LIM_HIGH  = 8'h2C;
   localparam logic [7:0] OFF_IO_BASE_HIGH   = 8'h30;

   // Dword indexes derived from the byte offsets
   localparam logic [5:0] DW_PREF_PAIR  = OFF_PREF_BASE[7:2];
   localparam logic [5:0] DW_BASE_HIGH  = OFF_PREF_BASE_HIGH[7:2];
   localparam logic [5:0] DW_LIM_HIGH   = OFF_PREF_LIM_HIGH[7:2];
   localparam logic [5:0] DW_IO_HIGH    = OFF_IO_BASE_HIGH[7:2];

   // ************************************************************
   // Field layout and reset values
   // ************************************************************
   localparam int         FIELD_W       = 12;
   localparam int         FIELD_LSB     = 4;
   localparam int         LIMIT_LANE    = 16;
   localparam int         LOW_W         = 20;
   localparam int         IO_HIGH_W     = 16;
   localparam logic [3:0] WIDE_IND      = 4'h1;
   localparam logic [FIELD_W-1:0] FIELD_RST = 12'h000;
   localparam logic [31:0]        WORD_RST  = 32'h0000_0000;
   localparam logic [IO_HIGH_W-1:0] IO_HIGH_RST = 16'h0000;
   localparam logic [LOW_W-1:0]   LOW_ONES  = 20'hFFFFF;
   localparam logic [LOW_W-1:0]   LOW_ZEROS = 20'h00000;
   localparam logic [15:0]        IO_LOW_ZEROS = 16'h0000;
   localparam logic [31:0]        READ_ZERO = 32'h0000_0000;

   typedef logic [31:0] bpw_word_t;

endpackage
`default_nettype wire

/* bpw_win_if.sv */
// Window bounds passed from the register bank to the address comparator
`timescale 1ns/100ps
`default_nettype none
interface bpw_win_if;
   logic [63:0] prefBase;    // Full prefetch window bottom
   logic [63:0] prefLimit;   // Full prefetch window top
   logic [31:0] io_window_bottom_field;      // I/O window bottom
   logic [31:0] ioLimit;     // I/O window top

   modport regs (output prefBase, output prefLimit, output io_window_bottom_field, output ioLimit);
   modport cmp  (input prefBase, input prefLimit, input io_window_bottom_field, input ioLimit);
endinterface
`default_nettype wire

/* bpw_window_cmp.sv */
// Address comparator deciding which transactions fall in a window
`timescale 1ns/100ps
`default_nettype none
module bpw_window_cmp (
   input  wire logic        ref_clk,      // Core clock
   input  wire logic        rst,          // Synchronous reset, high
   bpw_win_if.cmp           win,          // Window bounds
   input  wire logic        txnValid,     // Transaction offered
   input  wire logic        txnIsIo,      // 1 = I/O, 0 = memory
   input  wire logic [63:0] txnAddr,      // Transaction address
   output logic             fwdPrefetch,  // Memory hit in window
   output logic             fwdIo         // I/O hit in window
);
   logic fwdPrefetch_r;
   logic fwdPrefetch_nxt;
   logic fwdIo_r;
   logic fwdIo_nxt;

   // Inclusive range checks; an inverted window never hits
   always_comb begin
      fwdPrefetch_nxt = txnValid && !txnIsIo
                        && (txnAddr >= win.prefBase)
                        && (txnAddr <= win.prefLimit);
      fwdIo_nxt       = txnValid && txnIsIo
                        && (txnAddr[63:32] == 32'h0000_0000)
                        && (txnAddr[31:0] >= win.io_window_bottom_field)
                        && (txnAddr[31:0] <= win.ioLimit);
   end

   // Registered decision, one cycle after the offer
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fwdPrefetch_r <= 1'b0;
         fwdIo_r       <= 1'b0;
      end else begin
         fwdPrefetch_r <= fwdPrefetch_nxt;
         fwdIo_r       <= fwdIo_nxt;
      end
   end

   assign fwdPrefetch = fwdPrefetch_r;
   assign fwdIo       = fwdIo_r;
endmodule
`default_nettype wire

/* bpw_regs.sv */
// Prefetch and I/O window configuration registers with forwarding decode
`timescale 1ns/100ps
`default_nettype none
module bpw_regs (
   input  wire logic        ref_clk,        // Core clock, 40 MHz
   input  wire logic        rst,            // Synchronous reset, high
   // Configuration access port
   input  wire logic        cfgWrEn,        // Write strobe, one cycle
   input  wire logic        cfgRdEn,        // Read strobe, one cycle
   input  wire logic [7:0]  cfgAddr,        // Byte offset, dword aligned
   input  wire logic [3:0]  cfgByteEn,      // Byte lane enables
   input  wire logic [31:0] cfgWrData,      // Write data
   output logic      [31:0] cfgRdData,      // Read data, registered
   output logic             cfgRdValid,     // Read data valid pulse
   // Transaction decode
   input  wire logic        txnValid,       // Transaction offered
   input  wire logic        txnIsIo,        // 1 = I/O, 0 = memory
   input  wire logic [63:0] txnAddr,        // Transaction address
   input  wire logic [31:0] ioLimitAddr,    // I/O window top, from outside
   output logic             fwdPrefetch,    // Forward as prefetchable
   output logic             fwdIo,          // Forward I/O downstream
   output logic      [63:0] prefBaseAddr,   // Full prefetch bottom
   output logic      [63:0] prefLimitAddr   // Full prefetch top
);

   // ************************************************************
   // State
   // ************************************************************
   logic [bpw_pkg::FIELD_W-1:0]   prefBottomField_r;
   logic [bpw_pkg::FIELD_W-1:0]   prefBottomField_nxt;
   logic [bpw_pkg::FIELD_W-1:0]   prefTopField_r;
   logic [bpw_pkg::FIELD_W-1:0]   prefTopField_nxt;
   bpw_pkg::bpw_word_t            prefBaseHigh_r;
   bpw_pkg::bpw_word_t            prefBaseHigh_nxt;
   bpw_pkg::bpw_word_t            prefLimitHigh_r;
   bpw_pkg::bpw_word_t            prefLimitHigh_nxt;
   logic [bpw_pkg::IO_HIGH_W-1:0] ioWindowBottomField_r;
   logic [bpw_pkg::IO_HIGH_W-1:0] ioWindowBottomField_nxt;
   bpw_pkg::bpw_word_t            rdData_r;
   bpw_pkg::bpw_word_t            rdData_nxt;
   logic                          rdValid_r;
   logic                          rdValid_nxt;

   logic [5:0]                    dwIndex;
   logic [15:0]                   prefBottomReg;
   logic [15:0]                   prefTopReg;
   bpw_pkg::bpw_word_t            pairWord;
   bpw_pkg::bpw_word_t            mergedWord;
   bpw_pkg::bpw_word_t            currentWord;

   bpw_win_if win ();

   // Byte-lane merge; disabled lanes keep the stored byte
   function automatic bpw_pkg::bpw_word_t laneMerge(
      input bpw_pkg::bpw_word_t oldWord,
      input bpw_pkg::bpw_word_t newWord,
      input logic [3:0]         laneEn
   );
      bpw_pkg::bpw_word_t res;
      res = oldWord;
      for (int i = 0; i < 4; i++) begin
         if (laneEn[i]) begin
            res[i*8 +: 8] = newWord[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // ************************************************************
   // Register images as software sees them
   // ************************************************************

   // Low nibble is the fixed wide address indicator
   assign prefBottomReg = {prefBottomField_r, bpw_pkg::WIDE_IND};
   assign prefTopReg    = {prefTopField_r, bpw_pkg::WIDE_IND};
   assign pairWord      = {prefTopReg, prefBottomReg};
   assign dwIndex       = cfgAddr[7:2];

   // Image of the addressed dword, zero when unmapped
   always_comb begin
      case (dwIndex)
         bpw_pkg::DW_PREF_PAIR: begin
            currentWord = pairWord;
         end
         bpw_pkg::DW_BASE_HIGH: begin
            currentWord = prefBaseHigh_r;
         end
         bpw_pkg::DW_LIM_HIGH: begin
            currentWord = prefLimitHigh_r;
         end
         bpw_pkg::DW_IO_HIGH: begin
            // Upper half (I/O limit upper) lives outside this block
            currentWord = {bpw_pkg::IO_LOW_ZEROS, ioWindowBottomField_r};
         end
         default: begin
            currentWord = bpw_pkg::READ_ZERO;
         end
      endcase
   end

   // Write data merged into the addressed image
   assign mergedWord = laneMerge(currentWord, cfgWrData, cfgByteEn);

   // ************************************************************
   // Configuration writes
   // ************************************************************

   // Next values; only the writable fields are stored at all
   always_comb begin
      prefBottomField_nxt     = prefBottomField_r;
      prefTopField_nxt        = prefTopField_r;
      prefBaseHigh_nxt        = prefBaseHigh_r;
      prefLimitHigh_nxt       = prefLimitHigh_r;
      ioWindowBottomField_nxt = ioWindowBottomField_r;
      if (cfgWrEn) begin
         case (dwIndex)
            bpw_pkg::DW_PREF_PAIR: begin
               // Indicator nibbles are dropped, so they cannot change
               prefBottomField_nxt =
                  mergedWord[bpw_pkg::FIELD_LSB +: bpw_pkg::FIELD_W];
               prefTopField_nxt    =
                  mergedWord[bpw_pkg::LIMIT_LANE + bpw_pkg::FIELD_LSB +:
                             bpw_pkg::FIELD_W];
            end
            bpw_pkg::DW_BASE_HIGH: begin
               prefBaseHigh_nxt = mergedWord;
            end
            bpw_pkg::DW_LIM_HIGH: begin
               prefLimitHigh_nxt = mergedWord;
            end
            bpw_pkg::DW_IO_HIGH: begin
               ioWindowBottomField_nxt = mergedWord[bpw_pkg::IO_HIGH_W-1:0];
            end
            default: begin
               // Unmapped writes are dropped silently
               prefBaseHigh_nxt = prefBaseHigh_r;
            end
         endcase
      end
   end

   // Register the stored fields; defaults make the limit read 0001h
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prefBottomField_r     <= bpw_pkg::FIELD_RST;
         prefTopField_r        <= bpw_pkg::FIELD_RST;
         prefBaseHigh_r        <= bpw_pkg::WORD_RST;
         prefLimitHigh_r       <= bpw_pkg::WORD_RST;
         ioWindowBottomField_r <= bpw_pkg::IO_HIGH_RST;
      end else begin
         prefBottomField_r     <= prefBottomField_nxt;
         prefTopField_r        <= prefTopField_nxt;
         prefBaseHigh_r        <= prefBaseHigh_nxt;
         prefLimitHigh_r       <= prefLimitHigh_nxt;
         ioWindowBottomField_r <= ioWindowBottomField_nxt;
      end
   end

   // ************************************************************
   // Configuration reads
   // ************************************************************

   // Read returns the value before a same-cycle write lands
   always_comb begin
      rdValid_nxt = cfgRdEn;
      rdData_nxt  = rdData_r;
      if (cfgRdEn) begin
         rdData_nxt = currentWord;
      end
   end

   // Data holds until the next read; valid is a single pulse
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdData_r  <= bpw_pkg::READ_ZERO;
         rdValid_r <= 1'b0;
      end else begin
         rdData_r  <= rdData_nxt;
         rdValid_r <= rdValid_nxt;
      end
   end

   // Read port straight from the flip-flops
   assign cfgRdData  = rdData_r;
   assign cfgRdValid = rdValid_r;

   // ************************************************************
   // Full window bounds
   // ************************************************************

   // Base fills low bits with zeros, limit with ones
   assign win.prefBase  = {prefBaseHigh_r, prefBottomField_r,
                           bpw_pkg::LOW_ZEROS};
   assign win.prefLimit = {prefLimitHigh_r, prefTopField_r,
                           bpw_pkg::LOW_ONES};
   // Only the upper half is held here; the rest reads as zeros
   assign win.io_window_bottom_field    = {ioWindowBottomField_r, bpw_pkg::IO_LOW_ZEROS};
   assign win.ioLimit   = ioLimitAddr;

   // Prefetch bounds also leave the block for the other bridge decoders
   assign prefBaseAddr  = win.prefBase;
   assign prefLimitAddr = win.prefLimit;

   // ************************************************************
   // Forwarding decision
   // ************************************************************

   // Comparator registers its result, one cycle of latency
   bpw_window_cmp u_cmp (
      .ref_clk     (ref_clk),
      .rst         (rst),
      .win         (win.cmp),
      .txnValid    (txnValid),
      .txnIsIo     (txnIsIo),
      .txnAddr     (txnAddr),
      .fwdPrefetch (fwdPrefetch),
      .fwdIo       (fwdIo)
   );

endmodule
`default_nettype wire

/* bpw_regs_monitor.sv */
// Port checker for the prefetch window registers
`timescale 1ns/100ps
`default_nettype none
module bpw_regs_monitor (
   input wire logic        ref_clk,       // Clock
   input wire logic        rst,           // Reset
   input wire logic        cfgWrEn,       // Write strobe
   input wire logic [7:0]  cfgAddr,       // Offset
   input wire logic [3:0]  cfgByteEn,     // Lanes
   input wire logic [31:0] cfgWrData,     // Write data
   input wire logic        txnValid,      // Offer
   input wire logic        txnIsIo,       // I/O offer
   input wire logic [63:0] txnAddr,       // Offer address
   input wire logic        fwdPrefetch,   // Memory hit
   input wire logic [63:0] prefBaseAddr,  // Window bottom
   input wire logic [63:0] prefLimitAddr  // Window top
);
   // Sampled on the core clock; quiet while reset is held
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   a_top_ones: assert property (prefLimitAddr[19:0] == 20'hFFFFF)
      else $error("Top address low bits not all ones");
   a_bottom_zeros: assert property (prefBaseAddr[19:0] == 20'h00000)
      else $error("Bottom address low bits not zero");
   a_top_field: assert property (cfgWrEn && cfgAddr[7:2] == 6'h09 && cfgByteEn[3:2] == 2'b11
      |=> prefLimitAddr[31:20] == $past(cfgWrData[31:20])) else $error("Top field write lost");
   a_bottom_field: assert property (cfgWrEn && cfgAddr[7:2] == 6'h09
      && cfgByteEn[1:0] == 2'b11
      |=> prefBaseAddr[31:20] == $past(cfgWrData[15:4])) else $error("Bottom field write lost");
   a_top_upper: assert property (cfgWrEn && cfgAddr[7:2] == 6'h0B && cfgByteEn == 4'hF
      |=> prefLimitAddr[63:32] == $past(cfgWrData)) else $error("Top upper word write lost");
   a_bottom_upper: assert property (cfgWrEn && cfgAddr[7:2] == 6'h0A && cfgByteEn == 4'hF
      |=> prefBaseAddr[63:32] == $past(cfgWrData)) else $error("Bottom upper word write lost");
   a_window_hold: assert property (!cfgWrEn |=> $stable(prefBaseAddr)
      && $stable(prefLimitAddr)) else $error("Window moved without a write");
   a_pref_fwd: assert property (1'b1 |=> fwdPrefetch == $past(txnValid && !txnIsIo &&
      txnAddr >= prefBaseAddr && txnAddr <= prefLimitAddr)) else $error("Prefetch decision wrong");
endmodule
bind bpw_regs bpw_regs_monitor i_mon (.ref_clk(ref_clk), .rst(rst), .cfgWrEn(cfgWrEn),
   .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .txnValid(txnValid),
   .txnIsIo(txnIsIo), .txnAddr(txnAddr), .fwdPrefetch(fwdPrefetch),
   .prefBaseAddr(prefBaseAddr), .prefLimitAddr(prefLimitAddr));
`default_nettype wire

/* bpw_host_model.sv */
// Host model driving configuration accesses and transaction offers
`timescale 1ns/100ps
`default_nettype none
module bpw_host_model (
   input  wire logic        ref_clk,      // Clock
   output logic             cfgWrEn,      // Write strobe
   output logic             cfgRdEn,      // Read strobe
   output logic      [7:0]  cfgAddr,      // Offset
   output logic      [3:0]  cfgByteEn,    // Lanes
   output logic      [31:0] cfgWrData,    // Write data
   output logic             txnValid,     // Offer
   output logic             txnIsIo,      // I/O offer
   output logic      [63:0] txnAddr,      // Offer address
   output logic      [31:0] ioLimitAddr   // I/O window top
);
   // Both buses idle from time zero
   initial begin
      {cfgWrEn, cfgRdEn, txnValid, txnIsIo} = 4'h0;
      {cfgAddr, cfgByteEn, cfgWrData, txnAddr, ioLimitAddr} = '0;
   end
   // One access; the strobe stands for exactly the edge that takes it
   task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be,
      input logic [31:0] d);
      @(posedge ref_clk);
      {cfgWrEn, cfgRdEn, cfgAddr, cfgByteEn, cfgWrData} <= {wr, ~wr, a, be, d};
      @(posedge ref_clk);
      {cfgWrEn, cfgRdEn, cfgWrData} <= {2'b00, ~d}; // Released data must not linger
      #1;
   endtask
   // One offer; the answer is read just after the edge that takes it
   task automatic offer(input logic io, input logic [63:0] a, input logic [31:0] lim);
      @(posedge ref_clk);
      {txnValid, txnIsIo, txnAddr, ioLimitAddr} <= {1'b1, io, a, lim};
      @(posedge ref_clk);
      {txnValid, txnAddr} <= {1'b0, ~a};
      #1;
   endtask
endmodule
`default_nettype wire

/* tb.sv */
// Self-checking bench for the prefetch and I/O window registers
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic        ref_clk, rst, cfgWrEn, cfgRdEn, cfgRdValid, txnValid, txnIsIo, fwdPrefetch, fwdIo;
   logic [7:0]  cfgAddr;
   logic [3:0]  cfgByteEn;
   logic [31:0] cfgWrData, cfgRdData, ioLimitAddr;
   logic [63:0] txnAddr, prefBaseAddr, prefLimitAddr;
   int          bad_count = 0;
   int          n_compared = 0;
   // Reference images of 24h, 28h, 2Ch, 30h and one unmapped dword
   logic [31:0] img [5] = '{32'h0001_0001, 32'h0, 32'h0, 32'h0, 32'h0};
   logic [7:0]  offs [5] = '{8'h24, 8'h28, 8'h2C, 8'h30, 8'h3C};
   logic [31:0] wmsk [5] = '{32'hFFF0_FFF0, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_FFFF, 32'h0};
   // Block under test and the host that drives it
   bpw_regs i_dut (.ref_clk(ref_clk), .rst(rst), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
      .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
      .cfgRdValid(cfgRdValid), .txnValid(txnValid), .txnIsIo(txnIsIo), .txnAddr(txnAddr),
      .ioLimitAddr(ioLimitAddr), .fwdPrefetch(fwdPrefetch), .fwdIo(fwdIo),
      .prefBaseAddr(prefBaseAddr), .prefLimitAddr(prefLimitAddr));
   bpw_host_model i_host (.ref_clk(ref_clk), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
      .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .txnValid(txnValid),
      .txnIsIo(txnIsIo), .txnAddr(txnAddr), .ioLimitAddr(ioLimitAddr));
   // 40 MHz core clock
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Reads every offset, then offers both edges of each window to the decoder
   task automatic check_all(input logic [31:0] lim);
      logic [63:0] pb, pl, a [10];
      logic [31:0] iob;
      pb = {img[1], img[0][15:4], 20'h00000};
      pl = {img[2], img[0][31:20], 20'hFFFFF};
      iob = {img[3][15:0], 16'h0000};
      for (int k = 0; k < 5; k++) begin
         i_host.access(1'b0, offs[k], 4'h0, 32'h0000_0000);
         chk({31'h0, cfgRdValid, cfgRdData}, {32'h1, img[k]});
      end
      chk(prefBaseAddr, pb);
      chk(prefLimitAddr, pl);
      a = '{pb, pb - 64'h1, pl, pl + 64'h1, {$urandom, $urandom}, {32'h0, iob},
            {32'h0, iob - 32'h1}, {32'h0, lim}, {32'h0, lim + 32'h1}, {32'h1, iob}};
      for (int j = 0; j < 10; j++) begin
         i_host.offer(j > 4, a[j], lim);
         chk({63'h0, fwdPrefetch}, {63'h0, j < 5 && a[j] >= pb && a[j] <= pl});
         chk({63'h0, fwdIo}, {63'h0, j > 4 && a[j] >= iob && a[j] <= {32'h0, lim}});
      end
   endtask
   // Reset, then directed and random writes, each followed by a full check
   initial begin
      logic [31:0] d, m;
      logic [3:0]  be;
      int          k;
      void'($urandom(5));
      rst = 1'b1;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      check_all(32'hFFFF_FFFF);
      for (int n = 0; n < 60; n++) begin
         k = (n < 4) ? n : $urandom_range(4, 0);
         be = (n < 4) ? 4'hF : 4'($urandom);
         d = (n == 0) ? 32'h8FF0_1230 : $urandom;
         if (k == 1 || k == 2) d[31:2] = 30'h0; // Small upper words keep windows reachable
         m = wmsk[k] & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
         i_host.access(1'b1, offs[k], be, d);
         img[k] = (img[k] & ~m) | (d & m);
         check_all($urandom);
      end
      // Second reset mid-run; every register must fall back to its reset image
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      img = '{32'h0001_0001, 32'h0, 32'h0, 32'h0, 32'h0};
      #1;
      chk(prefLimitAddr, 64'h0000_0000_000F_FFFF);
      check_all($urandom);
      end_sim();
   end
endmodule
`default_nettype wire
